// File: tfr_task_file.v
// command block task file of the flash disk: data port, feature,
// count and address registers
// assumes host strobes already synchronous to clk_sys, one pulse per access
//
// Overview of operation
// - sixteen bit data port, high and low
// - each data access moves one buffer word unless the write fifo is full or the buffer is empty
// - data port decodes at offset zero, error register at offset one
// - high-byte-only write at zero loads feature
// - count zero means 256 sectors
// - successful completion leaves count zero
// - failed completion leaves sectors remaining
// - sector register gives sector or bits 7-0
// - cylinder low gives cylinder or bits 15-8
// - cylinder high gives cylinder or bits 23-16
// - mode flag picks chs or block addressing
// - block bits 27-24 from head select bits
`timescale 1ns/1ns
`include "tfr_defines.vh"

module tfr_task_file (
	input  wire        clk_sys,
	input  wire        rst_b,
	input  wire [2:0]  host_addr,
	input  wire        low_byte_enable_n,
	input  wire        high_byte_enable_n,
	input  wire        host_wr,
	input  wire        host_rd,
	input  wire [15:0] host_wdata,
	output reg  [15:0] host_rdata,
	output wire        host_wr_ready,
	output wire        buf_wr_valid,
	input  wire        buf_wr_ready,
	output wire [15:0] buf_wr_data,
	input  wire        buf_rd_valid,
	output wire        buf_rd_ready,
	input  wire [15:0] buf_rd_data,
	input  wire [7:0]  error_code,
	input  wire        cmd_start,
	input  wire        sector_done,
	input  wire        cmd_done,
	input  wire        cmd_ok,
	output reg  [7:0]  command_feature,
	output reg  [8:0]  sectors_requested,
	output reg  [8:0]  sectors_left,
	output reg         logical_block_mode,
	output reg  [27:0] block_address,
	output reg  [7:0]  start_sector,
	output reg  [15:0] start_cylinder,
	output reg  [3:0]  head_select_bits
);

	// ***************************************************************
	// decode
	// ***************************************************************
	function sel;
		input [2:0] a;
		input [2:0] ofs;
		begin
			sel = (a == ofs);
		end
	endfunction

	function [8:0] expand_count;
		input [7:0] c;
		begin
			expand_count = (c == 8'h00) ? `TFR_FULL_COUNT : {1'b0, c};
		end
	endfunction

	wire any_lane   = !low_byte_enable_n | !high_byte_enable_n;
	wire feat_write = host_wr & sel(host_addr, `TFR_OFS_DATA)
	                  & !high_byte_enable_n & low_byte_enable_n;
	// shared offset: a high-byte-only write goes to feature, not data
	wire data_write = host_wr & sel(host_addr, `TFR_OFS_DATA)
	                  & !low_byte_enable_n;
	wire data_read  = host_rd & sel(host_addr, `TFR_OFS_DATA) & any_lane;
	wire byte_wr    = host_wr & !low_byte_enable_n;

	// ***************************************************************
	// registers
	// ***************************************************************
	reg [7:0] transfer_sector_count;
	reg [7:0] start_sector_number;
	reg [7:0] cylinder_low_byte;
	reg [7:0] cylinder_high_byte;
	reg [7:0] device_head;
	reg       busy;
	reg [15:0] data_hold;

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;
	reg [1:0] state;
	reg [1:0] next_state;

	always @* begin
		case (state)
		ST_IDLE: next_state = cmd_start ? ST_RUN : ST_IDLE;
		ST_RUN:  next_state = cmd_done ? ST_IDLE : ST_RUN;
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			busy  <= 1'b0;
		end else begin
			state <= next_state;
			busy  <= (next_state == ST_RUN);
		end
	end

	// ***************************************************************
	// data path: writes through the fifo, reads straight from the buffer, at most one word per access
	// ***************************************************************
	tfr_fifo #(
		.WIDTH (`TFR_FIFO_WIDTH),
		.DEPTH (`TFR_FIFO_DEPTH),
		.AW    (2)
	) u_wr_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (data_write),
		.in_ready  (host_wr_ready),
		.in_data   (host_wdata),
		.out_valid (buf_wr_valid),
		.out_ready (buf_wr_ready),
		.out_data  (buf_wr_data)
	);

	// a read pops one buffer word; an empty buffer returns the last word
	assign buf_rd_ready = data_read;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			data_hold <= `TFR_RST_WORD;
		else if (data_read & buf_rd_valid)
			data_hold <= buf_rd_data;
	end

	// ***************************************************************
	// command block register writes and progress updates
	// ***************************************************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			command_feature       <= `TFR_RST_BYTE;
			transfer_sector_count <= `TFR_RST_BYTE;
			start_sector_number   <= `TFR_RST_BYTE;
			cylinder_low_byte     <= `TFR_RST_BYTE;
			cylinder_high_byte    <= `TFR_RST_BYTE;
			device_head           <= `TFR_RST_BYTE;
			sectors_requested     <= 9'h000;
			sectors_left          <= 9'h000;
		end else begin
			if (feat_write)
				command_feature <= host_wdata[15:8];
			if (byte_wr & sel(host_addr, `TFR_OFS_FEATURE))
				command_feature <= host_wdata[7:0];
			// count, sector, cylinder and device/head writes are taken only while idle, so addresses stay put
			if (byte_wr & !busy) begin
				if (sel(host_addr, `TFR_OFS_COUNT))
					transfer_sector_count <= host_wdata[7:0];
				if (sel(host_addr, `TFR_OFS_SECTOR))
					start_sector_number <= host_wdata[7:0];
				if (sel(host_addr, `TFR_OFS_CYL_LOW))
					cylinder_low_byte <= host_wdata[7:0];
				if (sel(host_addr, `TFR_OFS_CYL_HIGH))
					cylinder_high_byte <= host_wdata[7:0];
				if (sel(host_addr, `TFR_OFS_DEV_HEAD))
					device_head <= host_wdata[7:0];
			end
			if (cmd_start & (state == ST_IDLE)) begin
				sectors_requested <= expand_count(transfer_sector_count);
				sectors_left      <= expand_count(transfer_sector_count);
			end else if (state == ST_RUN) begin
				if (cmd_done & cmd_ok)
					transfer_sector_count <= 8'h00;
				else if (cmd_done)
					transfer_sector_count <= sectors_left[7:0];
				else if (sector_done & (sectors_left != 9'h000))
					sectors_left <= sectors_left - 9'h001;
				if (cmd_done & cmd_ok)
					sectors_left <= 9'h000;
			end
		end
	end

	// ***************************************************************
	// address interpretation, registered outputs
	// ***************************************************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			logical_block_mode <= 1'b0;
			block_address      <= 28'h0000000;
			start_sector       <= `TFR_RST_BYTE;
			start_cylinder     <= `TFR_RST_WORD;
			head_select_bits   <= 4'h0;
		end else begin
			logical_block_mode <= device_head[`TFR_DH_MODE_BIT];
			head_select_bits   <= device_head[`TFR_DH_HEAD_MSB:`TFR_DH_HEAD_LSB];
			if (device_head[`TFR_DH_MODE_BIT]) begin
				block_address <= {device_head[`TFR_DH_HEAD_MSB:`TFR_DH_HEAD_LSB],
				                  cylinder_high_byte,
				                  cylinder_low_byte,
				                  start_sector_number};
				start_sector   <= `TFR_RST_BYTE;
				start_cylinder <= `TFR_RST_WORD;
			end else begin
				block_address  <= 28'h0000000;
				start_sector   <= start_sector_number;
				start_cylinder <= {cylinder_high_byte, cylinder_low_byte};
			end
		end
	end

	// ***************************************************************
	// read mux
	// ***************************************************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			host_rdata <= `TFR_RST_WORD;
		else if (host_rd) begin
			case (host_addr)
			`TFR_OFS_DATA:     host_rdata <= buf_rd_valid ? buf_rd_data : data_hold;
			`TFR_OFS_FEATURE:  host_rdata <= {8'h00, error_code};
			`TFR_OFS_COUNT:    host_rdata <= {8'h00, transfer_sector_count};
			`TFR_OFS_SECTOR:   host_rdata <= {8'h00, start_sector_number};
			`TFR_OFS_CYL_LOW:  host_rdata <= {8'h00, cylinder_low_byte};
			`TFR_OFS_CYL_HIGH: host_rdata <= {8'h00, cylinder_high_byte};
			`TFR_OFS_DEV_HEAD: host_rdata <= {8'h00, device_head};
			default:           host_rdata <= `TFR_RST_WORD;
			endcase
		end
	end

endmodule // tfr_task_file

// File: tfr_defines.vh
// task file register constants: offsets, field positions, reset values
// assumes inclusion by the task file register block, which passes the fifo sizes on
`ifndef TFR_DEFINES_VH
`define TFR_DEFINES_VH

// ***************************************************************
// task file offsets (three address lines)
// ***************************************************************
`define TFR_OFS_DATA      3'h0
`define TFR_OFS_FEATURE   3'h1
`define TFR_OFS_COUNT     3'h2
`define TFR_OFS_SECTOR    3'h3
`define TFR_OFS_CYL_LOW   3'h4
`define TFR_OFS_CYL_HIGH  3'h5
`define TFR_OFS_DEV_HEAD  3'h6

// ***************************************************************
// fields
// ***************************************************************
`define TFR_DH_MODE_BIT   6
`define TFR_DH_HEAD_MSB   3
`define TFR_DH_HEAD_LSB   0

// ***************************************************************
// reset values and counts
// ***************************************************************
`define TFR_RST_BYTE      8'h00
`define TFR_RST_WORD      16'h0000
`define TFR_FULL_COUNT    9'h100
`define TFR_FIFO_WIDTH    16
`define TFR_FIFO_DEPTH    4

`endif

// File: tfr_fifo.v
// small word fifo between the host data port and the sector buffer
// assumes one clock domain and synchronous valid/ready on both sides
`timescale 1ns/1ns

module tfr_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk_sys,
	input  wire             rst_b,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      fill;

	wire            push;
	wire            pop;

	// full mark sized to the fill counter so the compare is exact
	localparam [AW:0] FILL_FULL = DEPTH;

	assign in_ready  = (fill != FILL_FULL);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	always @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & !pop)
				fill <= fill + 1'b1;
			else if (pop & !push)
				fill <= fill - 1'b1;
		end
	end

endmodule // tfr_fifo

// File: tfr_task_file_properties.sv
// checker for the task file register block, ports only
// assumes one clock domain, bound onto every tfr_task_file
`timescale 1ns/1ns
module tfr_task_file_chk (
	input wire        clk_sys,
	input wire        rst_b,
	input wire [2:0]  host_addr,
	input wire        low_byte_enable_n,
	input wire        high_byte_enable_n,
	input wire        host_wr,
	input wire        host_rd,
	input wire [15:0] host_wdata,
	input wire [15:0] host_rdata,
	input wire        buf_rd_ready,
	input wire [15:0] buf_rd_data,
	input wire [7:0]  error_code,
	input wire        cmd_start,
	input wire        sector_done,
	input wire [7:0]  command_feature,
	input wire [8:0]  sectors_requested,
	input wire [8:0]  sectors_left,
	input wire        logical_block_mode,
	input wire [27:0] block_address,
	input wire [7:0]  start_sector,
	input wire [15:0] start_cylinder,
	input wire [3:0]  head_select_bits
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	feature_load_a: assert property (host_wr && host_addr == 3'h0 && !high_byte_enable_n
		&& low_byte_enable_n |-> ##2 command_feature == $past(host_wdata[15:8], 2))
		else $error("feature not loaded from high byte");
	data_pop_a: assert property (buf_rd_ready |-> host_rd && host_addr == 3'h0)
		else $error("buffer popped without data read");
	data_read_a: assert property (buf_rd_ready |=> host_rdata == $past(buf_rd_data))
		else $error("data read word wrong");
	error_read_a: assert property (host_rd && host_addr == 3'h1
		|=> host_rdata[7:0] == $past(error_code)) else $error("error read wrong");
	full_count_a: assert property (cmd_start |=> sectors_left == sectors_requested
		&& sectors_requested != 9'h000 && sectors_requested <= 9'h100)
		else $error("requested count wrong");
	count_down_a: assert property (sector_done && sectors_left != 9'h000 && !cmd_start
		|=> sectors_left == $past(sectors_left) - 9'h001) else $error("no count down");
	block_high_a: assert property (logical_block_mode
		|-> block_address[27:24] == head_select_bits) else $error("lba top bits");
	mode_split_a: assert property ($stable(logical_block_mode) |=> $stable(logical_block_mode)
		|-> (logical_block_mode ? start_cylinder == 16'h0000 : block_address == 28'h0000000))
		else $error("mode split wrong");
	addr_hold_a: assert property (!host_wr && !$past(host_wr) && !$past(host_wr, 2)
		|=> $stable(block_address) && $stable(start_cylinder)) else $error("address moved");
endmodule // tfr_task_file_chk
bind tfr_task_file tfr_task_file_chk u_chk (.clk_sys, .rst_b, .host_addr, .low_byte_enable_n,
	.high_byte_enable_n, .host_wr, .host_rd, .host_wdata, .host_rdata, .buf_rd_ready,
	.buf_rd_data, .error_code, .cmd_start, .sector_done, .command_feature, .sectors_requested,
	.sectors_left, .logical_block_mode, .block_address, .start_sector, .start_cylinder,
	.head_select_bits);

// File: tfr_sector_buffer.sv
// sector buffer model on the far side of the data fifo
// assumes valid/ready transfers on clk_sys; stall holds both sides off
`timescale 1ns/1ns
module tfr_sector_buffer (
	input  wire        clk_sys,
	input  wire        rst_b,
	input  wire        stall,
	input  wire        buf_wr_valid,
	output wire        buf_wr_ready,
	input  wire [15:0] buf_wr_data,
	output wire        buf_rd_valid,
	input  wire        buf_rd_ready,
	output wire [15:0] buf_rd_data
);
	logic [15:0] got [$];
	logic [7:0]  rd_cnt;
	assign buf_wr_ready = rst_b && !stall;
	assign buf_rd_valid = rst_b && !stall;
	// count changes every pop so a stale word can never pass
	assign buf_rd_data = {8'hC3, rd_cnt};
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_cnt <= 8'h00;
		end else begin
			if (buf_rd_ready)
				rd_cnt <= rd_cnt + 8'h01;
			if (buf_wr_valid && buf_wr_ready)
				got.push_back(buf_wr_data);
		end
	end
endmodule // tfr_sector_buffer

// File: tb_top.sv
// testbench for the task file register block
// assumes the host strobe contract: one-cycle pulses driven at falling edges
`timescale 1ns/1ns
module tb_top;
	reg         clk_sys, rst_b, host_wr, host_rd, low_byte_enable_n, high_byte_enable_n;
	reg         cmd_start, sector_done, cmd_done, cmd_ok, stall;
	reg  [2:0]  host_addr;
	reg  [15:0] host_wdata;
	reg  [7:0]  error_code;
	wire        host_wr_ready, buf_wr_valid, buf_wr_ready, buf_rd_valid, buf_rd_ready;
	wire        logical_block_mode;
	wire [15:0] host_rdata, buf_wr_data, buf_rd_data, start_cylinder;
	wire [7:0]  command_feature, start_sector;
	wire [8:0]  sectors_requested, sectors_left;
	wire [27:0] block_address;
	wire [3:0]  head_select_bits;
	integer     num_errors, checks, i;
	tfr_task_file u_dut (.clk_sys, .rst_b, .host_addr, .low_byte_enable_n, .high_byte_enable_n,
		.host_wr, .host_rd, .host_wdata, .host_rdata, .host_wr_ready, .buf_wr_valid,
		.buf_wr_ready, .buf_wr_data, .buf_rd_valid, .buf_rd_ready, .buf_rd_data, .error_code,
		.cmd_start, .sector_done, .cmd_done, .cmd_ok, .command_feature, .sectors_requested,
		.sectors_left, .logical_block_mode, .block_address, .start_sector, .start_cylinder,
		.head_select_bits);
	tfr_sector_buffer u_buf (.clk_sys, .rst_b, .stall, .buf_wr_valid, .buf_wr_ready,
		.buf_wr_data, .buf_rd_valid, .buf_rd_ready, .buf_rd_data);
	task check(input string what, input logic [27:0] seen, input logic [27:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr(input [2:0] a, input [1:0] en_n, input [15:0] d);
		@(negedge clk_sys);
		host_addr = a;
		{high_byte_enable_n, low_byte_enable_n} = en_n;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge clk_sys);
		host_wr = 1'b0;
	endtask
	// byte registers compare the low byte only; the upper lane is not defined
	task rd(input [2:0] a, input string what, input [15:0] exp, input full);
		@(negedge clk_sys);
		host_addr = a;
		{high_byte_enable_n, low_byte_enable_n} = 2'b00;
		host_rd = 1'b1;
		@(negedge clk_sys);
		host_rd = 1'b0;
		@(negedge clk_sys);
		check(what, full ? host_rdata : {8'h00, host_rdata[7:0]}, exp);
	endtask
	task pulse_start;
		@(negedge clk_sys);
		cmd_start = 1'b1;
		@(negedge clk_sys);
		cmd_start = 1'b0;
		@(negedge clk_sys);
	endtask
	task finish_cmd(input integer nsec, input ok);
		for (i = 0; i < nsec; i = i + 1) begin
			@(negedge clk_sys);
			sector_done = 1'b1;
			@(negedge clk_sys);
			sector_done = 1'b0;
		end
		cmd_ok = ok;
		cmd_done = 1'b1;
		@(negedge clk_sys);
		cmd_done = 1'b0;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		num_errors = num_errors + 1;
		close_out;
	end
	initial begin
		{rst_b, host_wr, host_rd, cmd_start, sector_done, cmd_done, cmd_ok, stall} = 8'h00;
		{high_byte_enable_n, low_byte_enable_n} = 2'b11;
		{host_addr, host_wdata, error_code} = {3'h0, 16'h0000, 8'h5A};
		{num_errors, checks} = {32'h0, 32'h0};
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		check("feature", command_feature, 28'h0000000);
		rd(3'h2, "count", 16'h0000, 1'b0);
		$display("test reset done");
		wr(3'h0, 2'b01, 16'hA5C3);
		repeat (2) @(negedge clk_sys);
		check("feature", command_feature, 28'h00000A5);
		wr(3'h6, 2'b00, 16'h00A3);
		wr(3'h3, 2'b00, 16'h0011);
		wr(3'h4, 2'b00, 16'h0022);
		wr(3'h5, 2'b00, 16'h0033);
		repeat (3) @(negedge clk_sys);
		check("sector", start_sector, 28'h0000011);
		check("cylinder", start_cylinder, 28'h0003322);
		check("chs block", block_address, 28'h0000000);
		rd(3'h5, "cyl high", 16'h0033, 1'b0);
		wr(3'h6, 2'b00, 16'h00E9);
		repeat (3) @(negedge clk_sys);
		check("lba", block_address, 28'h9332211);
		check("lba sector", start_sector, 28'h0000000);
		check("mode", logical_block_mode, 28'h0000001);
		check("heads", head_select_bits, 28'h0000009);
		$display("test address done");
		wr(3'h2, 2'b00, 16'h0000);
		pulse_start;
		check("requested", sectors_requested, 28'h0000100);
		wr(3'h3, 2'b00, 16'h0077);
		finish_cmd(2, 1'b0);
		rd(3'h2, "count fail", 16'h00FE, 1'b0);
		check("held", block_address, 28'h9332211);
		wr(3'h2, 2'b00, 16'h0003);
		pulse_start;
		finish_cmd(3, 1'b1);
		rd(3'h2, "count ok", 16'h0000, 1'b0);
		$display("test count done");
		stall = 1'b1;
		for (i = 0; i < 5; i = i + 1)
			wr(3'h0, 2'b00, 16'h1000 + i[15:0]);
		check("fifo full", host_wr_ready, 28'h0000000);
		stall = 1'b0;
		repeat (6) @(negedge clk_sys);
		check("words", u_buf.got.size(), 28'h0000004);
		for (i = 0; i < 4; i = i + 1)
			check("word", u_buf.got[i], 28'h0001000 + i);
		rd(3'h0, "data", 16'hC300, 1'b1);
		rd(3'h0, "data", 16'hC301, 1'b1);
		rd(3'h1, "error", 16'h005A, 1'b0);
		$display("test data done");
		close_out;
	end
endmodule // tb_top
